// ### rtl/sarctl_top.sv
// SAR converter control: trigger select, channel select, phase sequencing, AXI4-Lite registers.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "sarctl_map.svh"

module sarctl_top
    import sarctl_pkg::*;
#(
    parameter int RES_BITS = 12,
    parameter int ACQ_CYCLES = `SARCTL_ACQ_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_start_pin,
    input wire logic timer1_overflow,
    input wire logic timer0_overflow,
    input wire logic programmable_logic_array_trigger,
    input wire logic comparator_out,
    output sarctl_switch_type switch_ctrl,
    output logic [RES_BITS-1:0] dac_code,
    output logic conversion_in_progress_pin,
    output logic irq
);

    // Result layout and 8-bit acquisition counter limit what can be served
    if (RES_BITS != 12 || ACQ_CYCLES < 1 || ACQ_CYCLES > 255) begin
        $error("sarctl_top: unsupported parameters");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] psel;
        logic [7:0] nsel;
        logic ready;
        logic ready_mask;
        logic [31:0] result;
        sarctl_state_type st;
        logic [7:0] acq_cnt;
        logic [3:0] bit_idx;
        logic [RES_BITS-1:0] sar;
        logic [RES_BITS-1:0] dac;
        logic single_req;
        logic [2:0] pin_sync;
        logic pin_level;
        logic awv;
        logic [7:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] bresp;
        sarctl_switch_type sw;
        logic busy_pin;
        logic irq;
    } sarctl_regs_type;

    sarctl_regs_type r_reg, r_next;

    // ==========================================================
    // Helpers
    function automatic logic trig_ok(input logic [2:0] t);
        trig_ok = (t <= 3'h5);
    endfunction

    function automatic logic pos_ok(input logic [4:0] c);
        pos_ok = (c <= 5'h13);
    endfunction

    function automatic logic neg_ok(input logic [4:0] c);
        neg_ok = (c <= 5'h10);
    endfunction

    function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        wmerge = s[0] ? d[7:0] : old;
    endfunction

    logic [2:0] trig_type;
    logic [1:0] mode;
    logic cfg_ok;
    logic start_evt;
    logic pin_rise;

    assign trig_type = r_reg.ctrl[`SARCTL_CTRL_TYPE_LSB +: 3];
    assign mode = r_reg.ctrl[`SARCTL_CTRL_MODE_LSB +: 2];
    assign cfg_ok = trig_ok(trig_type) && pos_ok(r_reg.psel[4:0]) && neg_ok(r_reg.nsel[4:0])
        && (mode != 2'h3) && r_reg.ctrl[`SARCTL_CTRL_EN_BIT] && r_reg.ctrl[`SARCTL_CTRL_PWR_BIT];
    // Pin edge counts once stages two and three agree
    assign pin_rise = (r_reg.pin_sync[2:1] == 2'b11) && !r_reg.pin_level;

    always_comb begin
        case (trig_type)
            SARCTL_TRIG_PIN: start_evt = pin_rise;
            SARCTL_TRIG_TMR1: start_evt = timer1_overflow;
            SARCTL_TRIG_TMR0: start_evt = timer0_overflow;
            SARCTL_TRIG_SINGLE: start_evt = r_reg.single_req;
            SARCTL_TRIG_CONT: start_evt = 1'b1;
            SARCTL_TRIG_PLA: start_evt = programmable_logic_array_trigger;
            default: start_evt = 1'b0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic do_write;
        logic do_read;
        logic rd_result;
        logic ready_set;
        logic [RES_BITS-1:0] trial;
        logic [RES_BITS-1:0] code;
        do_write = 1'b0;
        do_read = 1'b0;
        rd_result = 1'b0;
        ready_set = 1'b0;
        trial = '0;
        code = '0;
        r_next = r_reg;

        r_next.pin_sync = {r_reg.pin_sync[1:0], external_start_pin};
        if (r_reg.pin_sync[2] == r_reg.pin_sync[1]) begin
            r_next.pin_level = r_reg.pin_sync[2];
        end

        // AXI write channels, accepted in either order
        r_next.awready = !r_reg.awv && !r_reg.bvalid;
        r_next.wready = !r_reg.wv && !r_reg.bvalid;
        if (s_axi_awvalid && r_reg.awready) begin
            r_next.awv = 1'b1;
            r_next.awaddr = s_axi_awaddr;
            r_next.awready = 1'b0;
        end
        if (s_axi_wvalid && r_reg.wready) begin
            r_next.wv = 1'b1;
            r_next.wdata = s_axi_wdata;
            r_next.wstrb = s_axi_wstrb;
            r_next.wready = 1'b0;
        end
        if (r_reg.awv && r_reg.wv && !r_reg.bvalid) begin
            do_write = 1'b1;
            r_next.awv = 1'b0;
            r_next.wv = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = 2'b00;
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end

        // AXI read channel
        r_next.arready = !r_reg.rvalid && !r_reg.arready;
        if (s_axi_arvalid && r_reg.arready) begin
            do_read = 1'b1;
            r_next.arready = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp = 2'b00;
            if (s_axi_araddr == `SARCTL_CTRL_OFF) begin
                r_next.rdata = {24'h000000, r_reg.ctrl};
            end else if (s_axi_araddr == `SARCTL_PSEL_OFF) begin
                r_next.rdata = {24'h000000, r_reg.psel};
            end else if (s_axi_araddr == `SARCTL_NSEL_OFF) begin
                r_next.rdata = {24'h000000, r_reg.nsel};
            end else if (s_axi_araddr == `SARCTL_STAT_OFF) begin
                r_next.rdata = {30'h00000000, r_reg.st != SARCTL_IDLE, r_reg.ready};
            end else if (s_axi_araddr == `SARCTL_DATA_OFF) begin
                r_next.rdata = r_reg.result;
                rd_result = 1'b1;
            end else if (s_axi_araddr == `SARCTL_IRQS_OFF) begin
                r_next.rdata = {31'h00000000, r_reg.ready};
            end else if (s_axi_araddr == `SARCTL_IMSK_OFF) begin
                r_next.rdata = {31'h00000000, r_reg.ready_mask};
            end else begin
                r_next.rdata = 32'h00000000;
                r_next.rresp = 2'b10;
            end
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end

        if (do_write) begin
            if (r_reg.awaddr == `SARCTL_CTRL_OFF) begin
                r_next.ctrl = wmerge(r_reg.ctrl, r_reg.wdata, r_reg.wstrb);
                // Writing type 011 arms one software conversion
                if (r_reg.wstrb[0] && r_reg.wdata[2:0] == 3'h3) begin
                    r_next.single_req = 1'b1;
                end
            end else if (r_reg.awaddr == `SARCTL_PSEL_OFF) begin
                r_next.psel = wmerge(r_reg.psel, r_reg.wdata, r_reg.wstrb);
            end else if (r_reg.awaddr == `SARCTL_NSEL_OFF) begin
                r_next.nsel = wmerge(r_reg.nsel, r_reg.wdata, r_reg.wstrb);
            end else if (r_reg.awaddr == `SARCTL_IRQS_OFF) begin
                if (r_reg.wstrb[0] && r_reg.wdata[0]) begin
                    r_next.ready = 1'b0;
                end
            end else if (r_reg.awaddr == `SARCTL_IMSK_OFF) begin
                if (r_reg.wstrb[0]) begin
                    r_next.ready_mask = r_reg.wdata[0];
                end
            end else begin
                r_next.bresp = 2'b10;
            end
        end
        if (rd_result) begin
            r_next.ready = 1'b0;
        end

        // Conversion sequencer
        trial = r_reg.sar | (RES_BITS'(1) << r_reg.bit_idx);
        case (r_reg.st)
            SARCTL_IDLE: begin
                if (cfg_ok && start_evt) begin
                    r_next.st = SARCTL_ACQ;
                    r_next.acq_cnt = '0;
                    r_next.single_req = 1'b0;
                end
            end
            SARCTL_ACQ: begin
                if (!cfg_ok) begin
                    r_next.st = SARCTL_IDLE;
                end else if (r_reg.acq_cnt == 8'(ACQ_CYCLES - 1)) begin
                    r_next.st = SARCTL_CONV;
                    r_next.bit_idx = 4'(RES_BITS - 1);
                    r_next.sar = '0;
                end else begin
                    r_next.acq_cnt = r_reg.acq_cnt + 8'h01;
                end
            end
            SARCTL_CONV: begin
                // Comparator high keeps the trial bit
                if (comparator_out) begin
                    r_next.sar = trial;
                end
                if (r_reg.bit_idx == 4'h0) begin
                    r_next.st = SARCTL_DONE;
                end else begin
                    r_next.bit_idx = r_reg.bit_idx - 4'h1;
                end
            end
            SARCTL_DONE: begin
                code = r_reg.sar;
                if (mode == SARCTL_MODE_DIFF) begin
                    // Offset binary to two's complement
                    code[RES_BITS-1] = ~code[RES_BITS-1];
                    r_next.result = {{4{code[RES_BITS-1]}}, code, 16'h0000};
                end else begin
                    r_next.result = {4'h0, code, 16'h0000};
                end
                ready_set = 1'b1;
                r_next.st = SARCTL_IDLE;
            end
            default: r_next.st = SARCTL_IDLE;
        endcase
        // A finishing conversion wins over a clear in the same cycle
        if (ready_set) begin
            r_next.ready = 1'b1;
        end

        // Analog switch steering for the phase being entered
        r_next.sw = '0;
        r_next.sw.pos_channel = r_reg.psel[4:0];
        r_next.sw.neg_channel = r_reg.nsel[4:0];
        r_next.sw.neg_to_gnd = (mode == SARCTL_MODE_SE);
        if (r_next.st == SARCTL_ACQ) begin
            r_next.sw.inputs_connected = 1'b1;
            r_next.sw.comparator_balance = 1'b1;
            r_next.sw.neg_to_pin = (mode == SARCTL_MODE_DIFF)
                || (mode == SARCTL_MODE_PSEUDO);
        end else if (r_next.st == SARCTL_CONV) begin
            r_next.sw.inputs_connected = 1'b0;
            r_next.sw.neg_to_ref = (mode == SARCTL_MODE_PSEUDO);
        end
        r_next.busy_pin = r_reg.ctrl[`SARCTL_CTRL_BUSYEN_BIT]
            && (r_next.st == SARCTL_CONV || r_next.st == SARCTL_DONE);
        // Trial code registered so it stands for the whole comparator cycle
        r_next.dac = r_next.sar | (RES_BITS'(1) << r_next.bit_idx);
        r_next.irq = r_next.ready && r_next.ready_mask;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.ctrl <= `SARCTL_CTRL_RST;
            r_reg.psel <= `SARCTL_SEL_RST;
            r_reg.nsel <= `SARCTL_SEL_RST;
            r_reg.st <= SARCTL_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready = r_reg.wready;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;
    assign s_axi_rvalid = r_reg.rvalid;
    assign switch_ctrl = r_reg.sw;
    assign dac_code = r_reg.dac;
    assign conversion_in_progress_pin = r_reg.busy_pin;
    assign irq = r_reg.irq;

endmodule

// ### rtl/sarctl_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef SARCTL_MAP_SVH
`define SARCTL_MAP_SVH

// ==========================================================
// Register byte offsets
`define SARCTL_CTRL_OFF 8'h00
`define SARCTL_PSEL_OFF 8'h04
`define SARCTL_NSEL_OFF 8'h08
`define SARCTL_STAT_OFF 8'h0C
`define SARCTL_DATA_OFF 8'h10
`define SARCTL_IRQS_OFF 8'h14
`define SARCTL_IMSK_OFF 8'h18

// ==========================================================
// Control register fields
`define SARCTL_CTRL_TYPE_LSB 0
`define SARCTL_CTRL_MODE_LSB 3
`define SARCTL_CTRL_PWR_BIT 5
`define SARCTL_CTRL_BUSYEN_BIT 6
`define SARCTL_CTRL_EN_BIT 7
`define SARCTL_CTRL_RST 8'h00
`define SARCTL_SEL_RST 8'h00

// ==========================================================
// Timing
`define SARCTL_ACQ_NS 200
`define SARCTL_CLK_NS 10
`define SARCTL_ACQ_CYC ((`SARCTL_ACQ_NS + `SARCTL_CLK_NS - 1) / `SARCTL_CLK_NS)

`endif

// ### rtl/sarctl_pkg.sv
// Types shared by the converter control block.
package sarctl_pkg;

    typedef enum logic [2:0] {
        SARCTL_TRIG_PIN = 3'h0,
        SARCTL_TRIG_TMR1 = 3'h1,
        SARCTL_TRIG_TMR0 = 3'h2,
        SARCTL_TRIG_SINGLE = 3'h3,
        SARCTL_TRIG_CONT = 3'h4,
        SARCTL_TRIG_PLA = 3'h5
    } sarctl_trig_type;

    typedef enum logic [1:0] {
        SARCTL_MODE_SE = 2'h0,
        SARCTL_MODE_DIFF = 2'h1,
        SARCTL_MODE_PSEUDO = 2'h2
    } sarctl_mode_type;

    typedef enum {SARCTL_IDLE, SARCTL_ACQ, SARCTL_CONV, SARCTL_DONE} sarctl_state_type;

    // Analog switch controls toward the front end
    typedef struct packed {
        logic inputs_connected;
        logic comparator_balance;
        logic neg_to_pin;
        logic neg_to_ref;
        logic neg_to_gnd;
        logic [4:0] pos_channel;
        logic [4:0] neg_channel;
    } sarctl_switch_type;

endpackage

// ### bench/sarctl_properties.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module sarctl_properties
    import sarctl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire sarctl_switch_type switch_ctrl,
    input wire logic conversion_in_progress_pin
);
    wire conn = switch_ctrl.inputs_connected;
    wire bal = switch_ctrl.comparator_balance;
    wire gnd = switch_ctrl.neg_to_gnd;
    wire npin = switch_ctrl.neg_to_pin;
    wire nref = switch_ctrl.neg_to_ref;
    wire busy = conversion_in_progress_pin;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Properties
    property p_bal_acq; conn |-> bal; endproperty
    a_bal_acq: assert property (p_bal_acq) else $error("comparator free while tracking");
    property p_hold_conv; $fell(conn) |-> !conn [*8]; endproperty
    a_hold_conv: assert property (p_hold_conv) else $error("inputs back too early");
    property p_busy_disc; busy |-> !conn; endproperty
    a_busy_disc: assert property (p_busy_disc) else $error("inputs on while busy");
    property p_busy_len; $rose(busy) |-> busy [*8]; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy pulse too short");
    property p_neg_excl; gnd |-> !npin && !nref; endproperty
    a_neg_excl: assert property (p_neg_excl) else $error("negative path doubly tied");
    property p_ref_conv; nref |-> !conn && !npin; endproperty
    a_ref_conv: assert property (p_ref_conv) else $error("reference while tracking");
    // Both halves taken together: response after latch and commit
    property p_b_time;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid;
    endproperty
    a_b_time: assert property (p_b_time) else $error("write response late");
    property p_r_time; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
    a_r_time: assert property (p_r_time) else $error("read data late");
    c_conv: cover property ($rose(busy));
    c_pseudo: cover property (nref);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind sarctl_top sarctl_properties props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .switch_ctrl, .conversion_in_progress_pin);

// ### bench/sarctl_afe_model.sv
// Behavioural analog front end: sampling arrays and comparator.
`timescale 1ns/1ps
module sarctl_afe_model
    import sarctl_pkg::*;
(
    input wire logic aclk,
    input wire sarctl_switch_type switch_ctrl,
    input wire logic [11:0] dac_code,
    input wire logic [11:0] level,
    output logic comparator_out
);
    logic [11:0] held_reg = 12'h000;
    // Tracks only while connected, so an early disconnect shows as a wrong code
    always @(posedge aclk) if (switch_ctrl.inputs_connected) held_reg <= level;
    assign comparator_out = (dac_code <= held_reg);
endmodule

// ### bench/test_sar_adc_trigger_and_channel_control.sv
// Register-level bench for the converter control.
`timescale 1ns/1ps
`include "sarctl_map.svh"
module test_sar_adc_trigger_and_channel_control;
    import sarctl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF, trig = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, cmp, busy;
    logic [1:0] s_axi_bresp, s_axi_rresp, mode = 2'h0;
    logic [31:0] s_axi_rdata, v;
    logic [11:0] dac, level = 12'h000;
    logic [4:0] psel = 5'h00, nsel = 5'h00;
    sarctl_switch_type sw;
    int fails = 0;
    int num_checks = 0;
    logic [4:0] ptab [3] = '{5'h05, 5'h10, 5'h13};
    logic [4:0] ntab [3] = '{5'h00, 5'h10, 5'h0F};
    logic [11:0] ltab [3] = '{12'hA5C, 12'h123, 12'hFFF};
    // Differential: offset code 123 reads as 923 two's complement, sign-extended
    logic [31:0] etab [3] = '{32'h0A5C_0000, 32'hF923_0000, 32'h0FFF_0000};
    int ttab [5] = '{0, 1, 2, 5, 4};
    logic [3:0] gtab [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    logic [3:0] wtab [5] = '{4'h2, 4'h4, 4'h2, 4'h2, 4'h0};
    logic [7:0] rp [4] = '{8'h02, 8'h02, 8'h14, 8'h02};
    logic [7:0] rn [4] = '{8'h00, 8'h00, 8'h00, 8'h11};
    logic [7:0] rv [4] = '{8'hE6, 8'hFB, 8'hE3, 8'hE3};

    always #5 aclk = ~aclk;

    sarctl_top #(.ACQ_CYCLES(4)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_start_pin(trig[0]), .timer1_overflow(trig[1]), .timer0_overflow(trig[2]),
        .programmable_logic_array_trigger(trig[3]), .comparator_out(cmp), .switch_ctrl(sw),
        .dac_code(dac), .conversion_in_progress_pin(busy), .irq
    );
    sarctl_afe_model afe (.aclk, .switch_ctrl(sw), .dac_code(dac), .level, .comparator_out(cmp));

    // ==========================================================
    // Tasks
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic timeout;
        fails++;
        conclude();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        logic aw_s, w_s, b_s;
        logic [1:0] resp;
        n = 0;
        b_s = 1'b0;
        resp = 2'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Outputs read mid-cycle: they hold until the edge that samples them
        do begin
            @(negedge aclk);
            aw_s = s_axi_awready;
            w_s = s_axi_wready;
            b_s = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            n++;
            if (aw_s === 1'b1) s_axi_awvalid <= 1'b0;
            if (w_s === 1'b1) s_axi_wvalid <= 1'b0;
        end while (b_s !== 1'b1 && n < 60);
        s_axi_bready <= 1'b0;
        if (b_s !== 1'b1) timeout();
        chk(32'(resp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        logic ar_s, r_s;
        logic [1:0] resp;
        n = 0;
        r_s = 1'b0;
        resp = 2'h0;
        d = 32'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_s = s_axi_arready;
            r_s = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            n++;
            if (ar_s === 1'b1) s_axi_arvalid <= 1'b0;
        end while (r_s !== 1'b1 && n < 60);
        s_axi_rready <= 1'b0;
        if (r_s !== 1'b1) timeout();
        chk(32'(resp), 32'(er));
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(negedge aclk);
            n++;
        end
        if (irq !== 1'b1) timeout();
    endtask
    // Held four cycles so the pin survives its synchroniser
    task automatic fire(input logic [3:0] m);
        trig <= m;
        repeat (4) @(posedge aclk);
        trig <= 4'h0;
    endtask

    // ==========================================================
    // Switch monitor
    // Sampled mid-cycle, away from the edge that updates the switches
    always @(negedge aclk) begin
        if (aresetn === 1'b1 && sw.inputs_connected === 1'b1) begin
            chk(32'(busy), 32'h0);
            chk(32'(sw.neg_to_gnd), 32'(mode == 2'h0));
            chk(32'(sw.neg_to_pin), 32'(mode != 2'h0));
            chk(32'(sw.pos_channel), 32'(psel));
            chk(32'(sw.neg_channel), 32'(nsel));
        end
        if (busy === 1'b1) begin
            chk(32'(sw.neg_to_gnd), 32'(mode == 2'h0));
            if (sw.neg_to_ref === 1'b1) chk(32'(mode), 32'h2);
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) rc(8'(4 * i), 32'h0);
        wr(8'h1C, 32'h1, 2'h2);
        rd(8'h1C, v, 2'h2);
        chk(v, 32'h0);
        wr(`SARCTL_IMSK_OFF, 32'h1);
        for (int m = 0; m < 3; m++) begin
            mode <= 2'(m);
            psel <= ptab[m];
            nsel <= ntab[m];
            level <= ltab[m];
            wr(`SARCTL_PSEL_OFF, 32'(ptab[m]));
            wr(`SARCTL_NSEL_OFF, 32'(ntab[m]));
            wr(`SARCTL_CTRL_OFF, 32'h0E3 | 32'(m << 3));
            wait_irq();
            rc(`SARCTL_STAT_OFF, 32'h1);
            rc(`SARCTL_DATA_OFF, etab[m]);
            rc(`SARCTL_STAT_OFF, 32'h0);
            wr(`SARCTL_IRQS_OFF, 32'h1);
            repeat (2) @(posedge aclk);
            chk(32'(irq), 32'h0);
        end
        mode <= 2'h0;
        wr(`SARCTL_IMSK_OFF, 32'h0);
        wr(`SARCTL_CTRL_OFF, 32'h0E3);
        repeat (40) @(posedge aclk);
        chk(32'(irq), 32'h0);
        rc(`SARCTL_IRQS_OFF, 32'h1);
        rc(`SARCTL_DATA_OFF, 32'h0FFF_0000);
        wr(`SARCTL_IRQS_OFF, 32'h1);
        wr(`SARCTL_IMSK_OFF, 32'h1);
        level <= 12'h3C1;
        for (int i = 0; i < 5; i++) begin
            wr(`SARCTL_CTRL_OFF, 32'h0E0 | 32'(ttab[i]));
            if (ttab[i] != 4) begin
                fire(wtab[i]);
                repeat (4) @(posedge aclk);
                chk(32'(sw.inputs_connected), 32'h0);
                fire(gtab[i]);
            end
            wait_irq();
            rc(`SARCTL_DATA_OFF, 32'h03C1_0000);
            if (ttab[i] == 4) begin
                wr(`SARCTL_IRQS_OFF, 32'h1);
                wait_irq();
            end
            wr(`SARCTL_CTRL_OFF, 32'h060);
            repeat (40) @(posedge aclk);
            rd(`SARCTL_DATA_OFF, v);
            wr(`SARCTL_IRQS_OFF, 32'h1);
        end
        // Negative select first, so no legal pair exists while a start is armed
        for (int i = 0; i < 4; i++) begin
            wr(`SARCTL_NSEL_OFF, 32'(rn[i]));
            wr(`SARCTL_PSEL_OFF, 32'(rp[i]));
            wr(`SARCTL_CTRL_OFF, 32'(rv[i]));
            fire(4'hF);
            repeat (30) @(posedge aclk);
            chk(32'(sw.inputs_connected), 32'h0);
            rc(`SARCTL_STAT_OFF, 32'h0);
        end
        conclude();
    end
endmodule
